// File: hw/gpc_defs.vh
// Purpose: constants for the general-purpose pin controller
// Assumes: byte addresses on a 32-bit AXI4-Lite register bus
// Notes: definitions only, no logic
`ifndef GPC_DEFS_VH
`define GPC_DEFS_VH

// register bus address width
`define GPC_ADDR_W 8

// register byte offsets
`define GPC_OFS_OUT 8'h00
`define GPC_OFS_OUT_SET 8'h04
`define GPC_OFS_OUT_CLR 8'h08
`define GPC_OFS_IN 8'h0c
`define GPC_OFS_OE 8'h10
`define GPC_OFS_FSEL0 8'h14
`define GPC_OFS_FSEL1 8'h18
`define GPC_OFS_CHG_STATUS 8'h1c
`define GPC_OFS_CHG_ENABLE 8'h20
`define GPC_OFS_CHG_IDENT 8'h24
`define GPC_OFS_CHG_CLEAR 8'h28
`define GPC_OFS_CTRL 8'h2c

// control register fields
`define GPC_CTRL_SOFT_RST 0
`define GPC_CTRL_STRAP_LSB 4
`define GPC_STRAP_W 4
// strap bit that selects management-slave mode
`define GPC_STRAP_MSLV 0

// reset values
`define GPC_RST_OUT 32'h0000_0000
`define GPC_RST_OE 32'h0000_0000
`define GPC_RST_FSEL 32'h0000_0000
`define GPC_RST_ENABLE 32'h0000_0000

// function select codes
`define GPC_FSEL_NORMAL 2'h0
`define GPC_FSEL_ALT1 2'h1
`define GPC_FSEL_ALT2 2'h2
`define GPC_FSEL_ALT3 2'h3

// bus responses
`define GPC_RESP_OKAY 2'h0
`define GPC_RESP_SLVERR 2'h2

`endif

// File: hw/gpc_pin_sync.v
// Purpose: three-stage pin synchroniser with change detection
// Assumes: pins are asynchronous to aclk
// Notes: a change counts once stages two and three agree; the chain
// runs through reset so captured straps see the real pad levels
`timescale 1ns/1ns
module gpc_pin_sync #(
  parameter W = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire [W-1:0] pin_raw,
  output reg [W-1:0] level_q,
  output reg [W-1:0] change_q
);
  reg [W-1:0] s1_q; // first stage, read only by s2
  reg [W-1:0] s2_q; // second stage
  reg [W-1:0] s3_q; // third stage
  reg primed_q; // first settled sample taken
  wire [W-1:0] agree; // stages two and three agree

  assign agree = ~(s2_q ^ s3_q);

  // shift chain, settled level and change pulses
  always @(posedge aclk) begin
    // chain not reset: levels must be visible while reset is held
    s1_q <= pin_raw;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!aresetn) begin
      // level tracks the pads during reset, no change pulses
      level_q <= s3_q;
      change_q <= {W{1'b0}};
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      if (!primed_q) begin
        // first look after reset: load level, no change pulse
        level_q <= s3_q;
        change_q <= {W{1'b0}};
      end else begin
        level_q <= (level_q & ~agree) | (s3_q & agree);
        change_q <= agree & (s3_q ^ level_q);
      end
    end
  end
endmodule

// File: hw/gpc_top.v
// Purpose: general-purpose pin controller behind an AXI4-Lite slave
// Assumes: one clock aclk, synchronous active-low reset aresetn
// Notes: function select survives soft reset; straps caught in reset
//
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "gpc_defs.vh"
// Contract
// - each pin configured on its own
// - pins are inputs until output enable set
// - input register shows every pin level
// - output pins drive the output value bit
// - set alias sets the written one bits
// - clear alias clears the written one bits
// - aliases give race-free bit updates
// - function select cleared only by external reset
// - two select bits pick normal, alt1, alt2, alt3
// - slave mode straps take over slave pins
// - straps sampled during reset, pins free after
// - any level change sets status bit
// - only enabled changes reach the interrupt
// - ident reads status AND enable
module gpc_top #(
  parameter NPIN = 32,
  parameter [NPIN-1:0] ALT1_AVAIL = {NPIN{1'b1}},
  parameter [NPIN-1:0] ALT2_AVAIL = {NPIN{1'b1}},
  parameter [NPIN-1:0] ALT3_AVAIL = {NPIN{1'b1}},
  parameter STRAP_PIN_LSB = 28,
  parameter MSLV_MDC_PIN = 22,
  parameter MSLV_MDIO_PIN = 23
) (
  input wire aclk,
  input wire aresetn,
  input wire [`GPC_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`GPC_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NPIN-1:0] pin_in,
  output reg [NPIN-1:0] pin_out,
  output reg [NPIN-1:0] pin_oe,
  output wire [NPIN-1:0] pin_level,
  input wire [NPIN-1:0] alt1_out,
  input wire [NPIN-1:0] alt1_oe,
  input wire [NPIN-1:0] alt2_out,
  input wire [NPIN-1:0] alt2_oe,
  input wire [NPIN-1:0] alt3_out,
  input wire [NPIN-1:0] alt3_oe,
  output reg mslv_mdc,
  output reg mslv_mdio_in,
  input wire mslv_mdio_out,
  input wire mslv_mdio_oe,
  output reg [`GPC_STRAP_W-1:0] cpu_config_straps,
  output reg pin_change_irq
);

  // byte-lane merge of write data into an old word
  function [31:0] lane_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    integer b;
    begin
      lane_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          lane_merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  // byte-lane mask used by alias and clear writes
  function [31:0] lane_mask;
    input [31:0] wd;
    input [3:0] strb;
    integer b;
    begin
      lane_mask = 32'h0000_0000;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          lane_mask[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  // pin state registers
  reg [NPIN-1:0] pin_output_value_q; // driven level per pin
  reg [NPIN-1:0] pin_output_enable_q; // one means output
  reg [NPIN-1:0] pin_function_select0_q; // select code bit 0
  reg [NPIN-1:0] pin_function_select1_q; // select code bit 1
  reg [NPIN-1:0] pin_change_status_q; // sticky change flags
  reg [NPIN-1:0] pin_change_enable_q; // interrupt enables
  reg soft_rst_q; // one-cycle soft reset pulse
  wire [NPIN-1:0] pin_change; // change pulses from synchroniser
  wire [NPIN-1:0] pin_change_ident; // status and enable

  // bus slave state
  reg aw_held_q; // write address latched
  reg w_held_q; // write data latched
  reg [`GPC_ADDR_W-1:0] aw_addr_q; // latched write address
  reg [31:0] w_data_q; // latched write data
  reg [3:0] w_strb_q; // latched byte strobes
  wire wr_go; // both halves present, response free
  wire [31:0] wr_mask; // strobed write bits

  // input synchroniser feeding level and change detection
  gpc_pin_sync #(
    .W(NPIN)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin_raw(pin_in),
    .level_q(pin_level),
    .change_q(pin_change)
  );

  assign pin_change_ident = pin_change_status_q & pin_change_enable_q;
  assign wr_go = aw_held_q && w_held_q && !s_axi_bvalid;
  assign wr_mask = lane_mask(w_data_q, w_strb_q);

  // strap capture: follows pin levels while reset is low, then frozen
  always @(posedge aclk) begin
    if (!aresetn) begin
      cpu_config_straps <= pin_level[STRAP_PIN_LSB +: `GPC_STRAP_W];
    end
  end

  // write channel acceptance, either order, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= {`GPC_ADDR_W{1'b0}};
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `GPC_RESP_OKAY;
    end else begin
      // ready only for the cycle that takes the item
      s_axi_awready <= !aw_held_q && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !w_held_q && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        // perform write, raise response
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_q[1:0] != 2'h0 || aw_addr_q > `GPC_OFS_CTRL) begin
          s_axi_bresp <= `GPC_RESP_SLVERR;
        end else if (aw_addr_q == `GPC_OFS_IN ||
                     aw_addr_q == `GPC_OFS_CHG_STATUS ||
                     aw_addr_q == `GPC_OFS_CHG_IDENT) begin
          s_axi_bresp <= `GPC_RESP_SLVERR; // read-only
        end else begin
          s_axi_bresp <= `GPC_RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // soft reset pulse from the control register
  always @(posedge aclk) begin
    if (!aresetn) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr_go && aw_addr_q == `GPC_OFS_CTRL &&
                    wr_mask[`GPC_CTRL_SOFT_RST];
    end
  end

  // output value, enable and change enable: external or soft reset
  always @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      pin_output_value_q <= `GPC_RST_OUT;
      pin_output_enable_q <= `GPC_RST_OE;
      pin_change_enable_q <= `GPC_RST_ENABLE;
    end else if (wr_go) begin
      // each bus write touches only its own pins' bits
      if (aw_addr_q == `GPC_OFS_OUT) begin
        pin_output_value_q <= lane_merge(pin_output_value_q, w_data_q,
                                         w_strb_q);
      end else if (aw_addr_q == `GPC_OFS_OUT_SET) begin
        // single-cycle update, no read-modify-write by software
        pin_output_value_q <= pin_output_value_q | wr_mask;
      end else if (aw_addr_q == `GPC_OFS_OUT_CLR) begin
        pin_output_value_q <= pin_output_value_q & ~wr_mask;
      end else if (aw_addr_q == `GPC_OFS_OE) begin
        pin_output_enable_q <= lane_merge(pin_output_enable_q, w_data_q,
                                          w_strb_q);
      end else if (aw_addr_q == `GPC_OFS_CHG_ENABLE) begin
        pin_change_enable_q <= lane_merge(pin_change_enable_q, w_data_q,
                                          w_strb_q);
      end
    end
  end

  // function select: only the external reset clears it
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_function_select0_q <= `GPC_RST_FSEL;
      pin_function_select1_q <= `GPC_RST_FSEL;
    end else if (wr_go) begin
      if (aw_addr_q == `GPC_OFS_FSEL0) begin
        pin_function_select0_q <= lane_merge(pin_function_select0_q,
                                             w_data_q, w_strb_q);
      end else if (aw_addr_q == `GPC_OFS_FSEL1) begin
        pin_function_select1_q <= lane_merge(pin_function_select1_q,
                                             w_data_q, w_strb_q);
      end
    end
  end

  // sticky change status; a new change beats a clear
  always @(posedge aclk) begin
    if (!aresetn || soft_rst_q) begin
      pin_change_status_q <= {NPIN{1'b0}};
    end else if (wr_go && aw_addr_q == `GPC_OFS_CHG_CLEAR) begin
      pin_change_status_q <= (pin_change_status_q & ~wr_mask) |
                             pin_change;
    end else begin
      pin_change_status_q <= pin_change_status_q | pin_change;
    end
  end

  // interrupt line: high while any enabled status bit is set
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_change_irq <= 1'b0;
    end else begin
      pin_change_irq <= |pin_change_ident;
    end
  end

  // read channel: one read at a time, answer one cycle after taking
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `GPC_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `GPC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        if (s_axi_araddr[1:0] != 2'h0) begin
          s_axi_rresp <= `GPC_RESP_SLVERR;
        end else if (s_axi_araddr == `GPC_OFS_OUT) begin
          s_axi_rdata <= pin_output_value_q;
        end else if (s_axi_araddr == `GPC_OFS_IN) begin
          s_axi_rdata <= pin_level;
        end else if (s_axi_araddr == `GPC_OFS_OE) begin
          s_axi_rdata <= pin_output_enable_q;
        end else if (s_axi_araddr == `GPC_OFS_FSEL0) begin
          s_axi_rdata <= pin_function_select0_q;
        end else if (s_axi_araddr == `GPC_OFS_FSEL1) begin
          s_axi_rdata <= pin_function_select1_q;
        end else if (s_axi_araddr == `GPC_OFS_CHG_STATUS) begin
          s_axi_rdata <= pin_change_status_q;
        end else if (s_axi_araddr == `GPC_OFS_CHG_ENABLE) begin
          s_axi_rdata <= pin_change_enable_q;
        end else if (s_axi_araddr == `GPC_OFS_CHG_IDENT) begin
          s_axi_rdata <= pin_change_ident;
        end else if (s_axi_araddr == `GPC_OFS_CTRL) begin
          s_axi_rdata[`GPC_CTRL_STRAP_LSB +: `GPC_STRAP_W] <=
            cpu_config_straps;
        end else if (s_axi_araddr == `GPC_OFS_OUT_SET ||
                     s_axi_araddr == `GPC_OFS_OUT_CLR ||
                     s_axi_araddr == `GPC_OFS_CHG_CLEAR) begin
          s_axi_rdata <= 32'h0000_0000; // write-only, reads zero
        end else begin
          s_axi_rresp <= `GPC_RESP_SLVERR; // unmapped
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // per-pin routing from select code to pad drivers
  reg [NPIN-1:0] drv_out_d; // next pad level
  reg [NPIN-1:0] drv_oe_d; // next pad enable
  reg mslv_on; // management-slave mode active
  integer n;
  always @* begin
    drv_out_d = {NPIN{1'b0}};
    drv_oe_d = {NPIN{1'b0}};
    mslv_on = cpu_config_straps[`GPC_STRAP_MSLV];
    for (n = 0; n < NPIN; n = n + 1) begin
      // normal mode is the default for every pin
      drv_out_d[n] = pin_output_value_q[n];
      drv_oe_d[n] = pin_output_enable_q[n];
      case ({pin_function_select1_q[n], pin_function_select0_q[n]})
        `GPC_FSEL_ALT1: begin
          if (ALT1_AVAIL[n]) begin
            drv_out_d[n] = alt1_out[n];
            drv_oe_d[n] = alt1_oe[n];
          end
        end
        `GPC_FSEL_ALT2: begin
          if (ALT2_AVAIL[n]) begin
            drv_out_d[n] = alt2_out[n];
            drv_oe_d[n] = alt2_oe[n];
          end
        end
        `GPC_FSEL_ALT3: begin
          // absent function falls back to normal mode
          if (ALT3_AVAIL[n]) begin
            drv_out_d[n] = alt3_out[n];
            drv_oe_d[n] = alt3_oe[n];
          end
        end
        default: begin
          drv_out_d[n] = pin_output_value_q[n];
        end
      endcase
    end
    if (mslv_on) begin
      // slave interface owns its pins whatever the settings say
      drv_out_d[MSLV_MDC_PIN] = 1'b0;
      drv_oe_d[MSLV_MDC_PIN] = 1'b0;
      drv_out_d[MSLV_MDIO_PIN] = mslv_mdio_out;
      drv_oe_d[MSLV_MDIO_PIN] = mslv_mdio_oe;
    end
  end

  // pad drivers and slave inputs, all from flops
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= {NPIN{1'b0}};
      pin_oe <= {NPIN{1'b0}};
      mslv_mdc <= 1'b0;
      mslv_mdio_in <= 1'b0;
    end else begin
      pin_out <= drv_out_d;
      pin_oe <= drv_oe_d;
      // slave sees pin levels only while its mode is on
      mslv_mdc <= mslv_on & pin_level[MSLV_MDC_PIN];
      mslv_mdio_in <= mslv_on & pin_level[MSLV_MDIO_PIN];
    end
  end

endmodule

// File: tb/gpc_board.sv
// Purpose: board model on the far side of the pins
// Assumes: an undriven pin follows the board level
// Notes: a driven pin reads back its own drive
`timescale 1ns/1ns
module gpc_board #(
  parameter NPIN = 32
) (
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] board_lvl,
  output wire [NPIN-1:0] pin_in
);
  // pad level: own drive wins, else board level
  assign pin_in = (pin_out & pin_oe) | (board_lvl & ~pin_oe);
endmodule

// File: tb/gpc_top_assertions.sv
// Purpose: port checker for the pin controller
// Assumes: one clock, sync active-low reset
// Notes: bound to every gpc_top instance
`timescale 1ns/1ns
`include "gpc_defs.vh"
module gpc_chk #(
  parameter NPIN = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NPIN-1:0] pin_in,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  input wire [NPIN-1:0] pin_level,
  input wire mslv_mdc,
  input wire mslv_mdio_in,
  input wire [`GPC_STRAP_W-1:0] cpu_config_straps
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // pads released while reset is held
  reset_pads_off_a: assert property (disable iff (1'b0)
    !aresetn |=> pin_oe == '0 && pin_out == '0)
    else $error("pads driven after reset");
  // write answer held until accepted
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  // read answer held until accepted
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read answer dropped");
  write_answer_a: assert property (s_axi_awready && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held");
  err_data_zero_a: assert property (s_axi_rvalid
    && s_axi_rresp == `GPC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // a settled pad shows up as its level
  level_follow_a: assert property (
    $stable(pin_in) [*7] |-> pin_level == pin_in)
    else $error("pin level stale");
  // slave pins idle unless slave mode strapped
  slave_pins_off_a: assert property (
    !cpu_config_straps[`GPC_STRAP_MSLV] |-> !mslv_mdc && !mslv_mdio_in)
    else $error("slave pins active");
  // straps frozen once out of reset
  strap_hold_a: assert property ($past(aresetn)
    |-> $stable(cpu_config_straps))
    else $error("straps moved after reset");
endmodule

bind gpc_top gpc_chk #(.NPIN(NPIN)) gpc_chk_i (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .pin_level(pin_level), .mslv_mdc(mslv_mdc),
  .mslv_mdio_in(mslv_mdio_in), .cpu_config_straps(cpu_config_straps));

// File: tb/test_gpio_pin_controller.sv
// Purpose: register-level tests of the pin controller
// Assumes: AXI4-Lite master tasks, board model on pins
// Notes: straps come from board levels held during each reset
`timescale 1ns/1ns
`include "gpc_defs.vh"
module test_gpio_pin_controller;
  localparam [1:0] OK = `GPC_RESP_OKAY;
  localparam [1:0] ER = `GPC_RESP_SLVERR;
  logic aclk, aresetn;
  logic [7:0] aw_addr, ar_addr;
  logic aw_vld, aw_rdy, w_vld, w_rdy, b_vld, b_rdy;
  logic ar_vld, ar_rdy, r_vld, r_rdy;
  logic [31:0] w_data, r_data;
  logic [1:0] b_resp, r_resp;
  logic [31:0] pin_in, pin_out, pin_oe, board;
  logic [31:0] a1o, a2o, a3o, aoe; // alternate drives
  logic irq, mdc; // interrupt line, slave clock seen
  int fail_count, cmp_count;

  gpc_top gpc_top_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_vld),
    .s_axi_awready(aw_rdy), .s_axi_wdata(w_data), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
    .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
    .s_axi_rready(r_rdy), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_level(), .alt1_out(a1o), .alt1_oe(aoe),
    .alt2_out(a2o), .alt2_oe(aoe), .alt3_out(a3o), .alt3_oe(aoe),
    .mslv_mdc(mdc), .mslv_mdio_in(), .mslv_mdio_out(1'b0),
    .mslv_mdio_oe(1'b0), .cpu_config_straps(), .pin_change_irq(irq));

  gpc_board gpc_board_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .board_lvl(board), .pin_in(pin_in));

  // free-running clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // word compare, counts and reports
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // one write, ready for the answer from the start
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    logic done;
    @(posedge aclk);
    aw_addr <= a;
    w_data <= d;
    aw_vld <= 1'b1;
    w_vld <= 1'b1;
    b_rdy <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (aw_rdy) aw_vld <= 1'b0;
      if (w_rdy) w_vld <= 1'b0;
      done = b_vld;
    end
    b_rdy <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, b_resp});
  endtask

  // one read, data and answer code compared
  task rd(input string nm, input [7:0] a, input [31:0] e,
          input [1:0] er);
    logic done;
    @(posedge aclk);
    ar_addr <= a;
    ar_vld <= 1'b1;
    r_rdy <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge aclk);
      if (ar_rdy) ar_vld <= 1'b0;
      done = r_vld;
    end
    r_rdy <= 1'b0;
    chk(nm, e, r_data);
    chk("rresp", {30'h0, er}, {30'h0, r_resp});
  endtask

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // verdict and end of run
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    #100000;
    fail_count++;
    $display("watchdog expired");
    stop_test;
  end

  initial begin
    aresetn = 1'b0;
    {aw_vld, w_vld, b_rdy, ar_vld, r_rdy} = 5'h0;
    {aw_addr, ar_addr, w_data} = '0;
    board = 32'ha000_0000;
    a1o = 32'h0;
    a2o = 32'hffff_ffff;
    a3o = 32'hffff_ffff;
    aoe = 32'hffff_ffff;
    fail_count = 0;
    cmp_count = 0;
    tick(12);
    aresetn <= 1'b1;
    // reset values
    rd("out", `GPC_OFS_OUT, 32'h0, OK);
    rd("oe", `GPC_OFS_OE, 32'h0, OK);
    rd("fsel0", `GPC_OFS_FSEL0, 32'h0, OK);
    rd("fsel1", `GPC_OFS_FSEL1, 32'h0, OK);
    rd("enable", `GPC_OFS_CHG_ENABLE, 32'h0, OK);
    chk("pin_oe", 32'h0, pin_oe);
    rd("ctrl", `GPC_OFS_CTRL, 32'h0000_00a0, OK);
    $display("test reset done");
    // drive low byte, read every pad back
    wr(`GPC_OFS_OE, 32'h0000_00ff, OK);
    wr(`GPC_OFS_OUT, 32'h0000_005a, OK);
    tick(2);
    chk("pin_oe", 32'h0000_00ff, pin_oe);
    chk("pin_out", 32'h5a, {24'h0, pin_out[7:0]});
    tick(8);
    rd("in", `GPC_OFS_IN, 32'ha000_005a, OK);
    $display("test drive done");
    // back-to-back set and clear aliases
    wr(`GPC_OFS_OUT_SET, 32'h0000_0081, OK);
    wr(`GPC_OFS_OUT_CLR, 32'h0000_0012, OK);
    rd("out", `GPC_OFS_OUT, 32'h0000_00c9, OK);
    rd("set alias", `GPC_OFS_OUT_SET, 32'h0, OK);
    $display("test alias done");
    // refused accesses leave state alone
    wr(8'h30, 32'h1, ER);
    wr(8'h02, 32'hffff_ffff, ER);
    wr(`GPC_OFS_IN, 32'hffff_ffff, ER);
    rd("unmapped", 8'h30, 32'h0, ER);
    rd("out", `GPC_OFS_OUT, 32'h0000_00c9, OK);
    $display("test refuse done");
    // change detection and interrupt
    tick(10);
    wr(`GPC_OFS_CHG_CLEAR, 32'hffff_ffff, OK);
    rd("status", `GPC_OFS_CHG_STATUS, 32'h0, OK);
    wr(`GPC_OFS_CHG_ENABLE, 32'h0000_0100, OK);
    board <= board | 32'h0000_0200;
    tick(10);
    rd("status", `GPC_OFS_CHG_STATUS, 32'h0000_0200, OK);
    rd("ident", `GPC_OFS_CHG_IDENT, 32'h0, OK);
    chk("irq", 32'h0, {31'h0, irq});
    board <= board | 32'h0000_0100;
    tick(10);
    rd("status", `GPC_OFS_CHG_STATUS, 32'h0000_0300, OK);
    rd("ident", `GPC_OFS_CHG_IDENT, 32'h0000_0100, OK);
    chk("irq", 32'h1, {31'h0, irq});
    wr(`GPC_OFS_CHG_CLEAR, 32'h0000_0100, OK);
    tick(3);
    chk("irq", 32'h0, {31'h0, irq});
    rd("status", `GPC_OFS_CHG_STATUS, 32'h0000_0200, OK);
    $display("test change done");
    // pins 0..2 take codes 1, 2, 3; pin 3 stays normal
    wr(`GPC_OFS_FSEL0, 32'h0000_0005, OK);
    wr(`GPC_OFS_FSEL1, 32'h0000_0006, OK);
    tick(3);
    chk("alt pin_out", 32'he, {28'h0, pin_out[3:0]});
    chk("alt pin_oe", 32'hf, {28'h0, pin_oe[3:0]});
    $display("test select done");
    // soft reset keeps only the function select
    wr(`GPC_OFS_CTRL, 32'h0000_0001, OK);
    tick(2);
    rd("fsel0", `GPC_OFS_FSEL0, 32'h0000_0005, OK);
    rd("fsel1", `GPC_OFS_FSEL1, 32'h0000_0006, OK);
    rd("out", `GPC_OFS_OUT, 32'h0, OK);
    rd("oe", `GPC_OFS_OE, 32'h0, OK);
    rd("enable", `GPC_OFS_CHG_ENABLE, 32'h0, OK);
    chk("pin_oe", 32'h0000_0007, pin_oe);
    // external reset clears the select too; strap slave mode on
    board <= board | 32'h1000_0000;
    aresetn <= 1'b0;
    tick(12);
    aresetn <= 1'b1;
    rd("fsel0", `GPC_OFS_FSEL0, 32'h0, OK);
    chk("pin_oe", 32'h0, pin_oe);
    rd("ctrl", `GPC_OFS_CTRL, 32'h0000_00b0, OK);
    // slave pins ignore their output enables, slave sees the pad
    wr(`GPC_OFS_OE, 32'h00c0_0000, OK);
    board <= board | 32'h0040_0000;
    tick(8);
    chk("slave pin_oe", 32'h0, pin_oe);
    chk("mdc", 32'h1, {31'h0, mdc});
    $display("test reset kinds done");
    stop_test;
  end
endmodule
